// file: include/ipm_pkg.sv
// Purpose: shared types and constants for the interpolated-position bus master
// Assumes: one message-level link to the drive (sdo write, receive pdo2, sync, transmit pdo2)
// Notes:   the init table is a constant lookup, indexed by step
package ipm_pkg;

    typedef enum logic [1:0] {
        IPM_FR_SDO  = 2'h0,
        IPM_FR_PDO2 = 2'h1,
        IPM_FR_SYNC = 2'h2
    } ipm_kind_t;

    // one frame towards the drive
    typedef struct packed {
        ipm_kind_t   kind;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [2:0]  len;
        logic [31:0] data;
        logic [15:0] cmd;
    } ipm_frame_t;

    // transmit pdo2 content seen from the drive
    typedef struct packed {
        logic [15:0] state;
        logic [31:0] pos;
    } ipm_tpdo_t;

    localparam int          IPM_CLK_MHZ      = 100;
    localparam int          IPM_MS_NS        = 1000000;
    localparam int          IPM_CLK_NS       = 1000 / IPM_CLK_MHZ;
    localparam int          IPM_MS_CYCLES    = IPM_MS_NS / IPM_CLK_NS;
    localparam logic [4:0]  IPM_CYC_MS_MIN   = 5'h01;
    localparam logic [4:0]  IPM_CYC_MS_MAX   = 5'h14;
    localparam logic [4:0]  IPM_TOL_MIN      = 5'h01;
    localparam logic [4:0]  IPM_TOL_MAX      = 5'h14;
    localparam logic [4:0]  IPM_INIT_STEPS   = 5'h1E;
    localparam logic [2:0]  IPM_LOST_CYCLES  = 3'h3;
    localparam int          IPM_FIFO_DEPTH   = 4;
    localparam int          IPM_POS_W        = 32;

    // drive command word fields
    localparam logic [15:0] IPM_CW_SHUTDOWN  = 16'h0006;
    localparam logic [15:0] IPM_CW_SWITCH_ON = 16'h0007;
    localparam logic [15:0] IPM_CW_ENABLE    = 16'h000F;
    localparam int          IPM_CW_START_BIT = 4;
    localparam int          IPM_CW_HALT_BIT  = 8;
    localparam logic [15:0] IPM_CW_RESV_MASK = 16'h0260;
    // drive state word fields
    localparam int          IPM_SW_REACH_BIT = 10;
    localparam int          IPM_SW_MODE_BIT  = 12;

    localparam logic [15:0] IPM_OBJ_CYCLE    = 16'h60C2;
    localparam logic [15:0] IPM_OBJ_SYNC     = 16'h3022;
    localparam logic [7:0]  IPM_SUB_TOL      = 8'h04;

    // init write sequence: {index, sub, len, value}; cob-id steps add the node id
    function automatic logic [58:0] ipm_init_entry(input logic [4:0] step);
        case (step)
            5'h00:   ipm_init_entry = {16'h1400, 8'h01, 3'h4, 32'h80000200};
            5'h01:   ipm_init_entry = {16'h1800, 8'h01, 3'h4, 32'h80000180};
            5'h02:   ipm_init_entry = {16'h1401, 8'h01, 3'h4, 32'h00000300};
            5'h03:   ipm_init_entry = {16'h1801, 8'h01, 3'h4, 32'h00000280};
            5'h04:   ipm_init_entry = {16'h1402, 8'h01, 3'h4, 32'h80000400};
            5'h05:   ipm_init_entry = {16'h1802, 8'h01, 3'h4, 32'h80000380};
            5'h06:   ipm_init_entry = {16'h1403, 8'h01, 3'h4, 32'h80000500};
            5'h07:   ipm_init_entry = {16'h1803, 8'h01, 3'h4, 32'h80000480};
            5'h08:   ipm_init_entry = {16'h1401, 8'h02, 3'h1, 32'h00000001};
            5'h09:   ipm_init_entry = {16'h1801, 8'h02, 3'h1, 32'h00000001};
            5'h0A:   ipm_init_entry = {16'h6040, 8'h00, 3'h2, 32'h00000000};
            5'h0B:   ipm_init_entry = {16'h6040, 8'h00, 3'h2, 32'h00000080};
            5'h0C:   ipm_init_entry = {16'h1601, 8'h00, 3'h1, 32'h00000000};
            5'h0D:   ipm_init_entry = {16'h1601, 8'h01, 3'h4, 32'h60400010};
            5'h0E:   ipm_init_entry = {16'h1601, 8'h02, 3'h4, 32'h60C10120};
            5'h0F:   ipm_init_entry = {16'h1601, 8'h00, 3'h1, 32'h00000002};
            5'h10:   ipm_init_entry = {16'h1A01, 8'h00, 3'h1, 32'h00000000};
            5'h11:   ipm_init_entry = {16'h1A01, 8'h01, 3'h4, 32'h60410010};
            5'h12:   ipm_init_entry = {16'h1A01, 8'h02, 3'h4, 32'h60640020};
            5'h13:   ipm_init_entry = {16'h1A01, 8'h00, 3'h1, 32'h00000002};
            5'h14:   ipm_init_entry = {16'h3006, 8'h07, 3'h4, 32'h00020000};
            5'h15:   ipm_init_entry = {16'h3006, 8'h08, 3'h4, 32'h00000001};
            5'h16:   ipm_init_entry = {16'h6060, 8'h00, 3'h1, 32'h00000007};
            5'h17:   ipm_init_entry = {16'h3006, 8'h3D, 3'h2, 32'h00000001};
            5'h18:   ipm_init_entry = {16'h60C2, 8'h01, 3'h1, 32'h00000000};
            5'h19:   ipm_init_entry = {16'h3012, 8'h06, 3'h2, 32'h000003E8};
            5'h1A:   ipm_init_entry = {16'h3013, 8'h06, 3'h2, 32'h000003E8};
            5'h1B:   ipm_init_entry = {16'h3006, 8'h06, 3'h2, 32'h00000001};
            5'h1C:   ipm_init_entry = {16'h3022, 8'h04, 3'h2, 32'h00000000};
            5'h1D:   ipm_init_entry = {16'h3022, 8'h05, 3'h2, 32'h00000002};
            default: ipm_init_entry = '0;
        endcase
    endfunction

endpackage

// file: design/ipm_master.sv
// Purpose: bus master that initialises a servo drive for interpolated position and feeds it cyclically
// Assumes: frames leave by a valid/ready handshake; the link layer reports sdo acks and tpdo2 arrivals
// Notes:   one reference per cycle, data frame first and sync after it
`timescale 1ns/1ns

module ipm_fifo #(
    parameter int W = 32,
    parameter int D = 4
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign o_out_data  = mem_q[rd_q];
    assign o_out_valid = (cnt_q != '0);

    // ready is registered so the top output comes from a flop; costs nothing in depth
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wr_q       <= '0;
            rd_q       <= '0;
            cnt_q      <= '0;
            o_in_ready <= 1'b0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= i_in_data;
                wr_q        <= (wr_q == AW'(D-1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q      <= cnt_d;
            o_in_ready <= (cnt_d != (AW+1)'(D));
        end
    end
endmodule

module ipm_master #(
    parameter int MS_CYCLES = ipm_pkg::IPM_MS_CYCLES
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst,
    input  wire logic                  i_init,
    input  wire logic [6:0]            i_node_id,
    input  wire logic [4:0]            i_cycle_ms,
    input  wire logic [4:0]            i_sync_tol,
    input  wire logic                  i_run,
    input  wire logic                  i_halt,
    input  wire logic                  i_ref_valid,
    input  wire logic [31:0]           i_ref_pos,
    output logic                       o_ref_ready,
    output ipm_pkg::ipm_frame_t        o_tx,
    output logic                       o_tx_valid,
    input  wire logic                  i_tx_ready,
    input  wire logic                  i_sdo_ack,
    input  wire logic                  i_rx_valid,
    input  wire ipm_pkg::ipm_tpdo_t    i_rx,
    output logic                       o_init_done,
    output logic                       o_mode_active,
    output logic                       o_pos_reached,
    output logic                       o_link_lost,
    output logic [31:0]                o_act_pos
);
    typedef enum logic [2:0] {
        IPM_IDLE, IPM_SDO_SEND, IPM_SDO_WAIT, IPM_RUN_WAIT, IPM_RUN_PDO, IPM_RUN_SYNC
    } ipm_state_t;

    ipm_state_t  st_q;
    logic [4:0]  step_q;
    logic [6:0]  node_q;
    logic [4:0]  cyc_ms_q;
    logic [4:0]  tol_q;
    logic [31:0] pre_q;
    logic [4:0]  ms_q;
    logic [1:0]  en_q;
    logic [31:0] last_ref_q;
    logic [2:0]  miss_q;
    logic        rx_seen_q;

    logic [58:0] entry;
    logic [31:0] sdo_val;
    logic        is_cobid;
    logic        ms_tick;
    logic        cyc_end;
    logic        fifo_valid;
    logic [31:0] fifo_data;
    logic        fifo_pop;
    logic        tx_done;
    logic [15:0] cmd_word;
    logic [31:0] ref_now;
    logic [4:0]  cyc_clip;
    logic [4:0]  tol_clip;

    ipm_fifo #(
        .W(ipm_pkg::IPM_POS_W),
        .D(ipm_pkg::IPM_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_in_valid  (i_ref_valid),
        .i_in_data   (i_ref_pos),
        .o_in_ready  (o_ref_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_pop)
    );

    // init table lookup; cob-id steps carry the node id, cycle and tolerance come from the user
    assign entry    = ipm_pkg::ipm_init_entry(step_q);
    assign is_cobid = (step_q < 5'h08);
    assign cyc_clip = (i_cycle_ms < ipm_pkg::IPM_CYC_MS_MIN) ? ipm_pkg::IPM_CYC_MS_MIN :
                      (i_cycle_ms > ipm_pkg::IPM_CYC_MS_MAX) ? ipm_pkg::IPM_CYC_MS_MAX : i_cycle_ms;
    assign tol_clip = (i_sync_tol < ipm_pkg::IPM_TOL_MIN) ? ipm_pkg::IPM_TOL_MIN :
                      (i_sync_tol > ipm_pkg::IPM_TOL_MAX) ? ipm_pkg::IPM_TOL_MAX : i_sync_tol;
    assign sdo_val  = (entry[58:43] == ipm_pkg::IPM_OBJ_CYCLE) ? {27'h0, cyc_ms_q} :
                      (entry[58:43] == ipm_pkg::IPM_OBJ_SYNC && entry[42:35] == ipm_pkg::IPM_SUB_TOL)
                          ? {27'h0, tol_q} :
                      is_cobid ? entry[31:0] + {25'h0, node_q} : entry[31:0];

    assign ms_tick  = (pre_q == 32'(MS_CYCLES - 1));
    assign cyc_end  = ms_tick && (ms_q == cyc_ms_q - 5'h01);
    assign tx_done  = o_tx_valid && i_tx_ready;

    // a fresh reference is taken once per cycle; otherwise the last one is repeated
    assign fifo_pop = (st_q == IPM_RUN_PDO) && !o_tx_valid && fifo_valid;
    assign ref_now  = fifo_valid ? fifo_data : last_ref_q;

    // command word: enable power stage over three cycles before bit 4 may rise
    assign cmd_word = ((en_q == 2'h0) ? ipm_pkg::IPM_CW_SHUTDOWN :
                       (en_q == 2'h1) ? ipm_pkg::IPM_CW_SWITCH_ON :
                       (ipm_pkg::IPM_CW_ENABLE
                        | (16'(i_run && en_q == 2'h3) << ipm_pkg::IPM_CW_START_BIT)
                        | (16'(i_halt) << ipm_pkg::IPM_CW_HALT_BIT)))
                      & ~ipm_pkg::IPM_CW_RESV_MASK;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_q        <= IPM_IDLE;
            step_q      <= '0;
            node_q      <= '0;
            cyc_ms_q    <= ipm_pkg::IPM_CYC_MS_MIN;
            tol_q       <= ipm_pkg::IPM_TOL_MIN;
            o_tx        <= '0;
            o_tx_valid  <= 1'b0;
            o_init_done <= 1'b0;
            en_q        <= '0;
            last_ref_q  <= '0;
        end else begin
            if (tx_done) begin
                o_tx_valid <= 1'b0;
            end
            case (st_q)
                IPM_IDLE: begin
                    if (i_init) begin
                        node_q   <= i_node_id;
                        cyc_ms_q <= cyc_clip;
                        tol_q    <= tol_clip;
                        step_q   <= '0;
                        st_q     <= IPM_SDO_SEND;
                    end
                end
                IPM_SDO_SEND: begin
                    // table order itself gives tolerance before activation and maps before counts
                    o_tx       <= '{ipm_pkg::IPM_FR_SDO, entry[58:43], entry[42:35], entry[34:32], sdo_val,
                                    16'h0000};
                    o_tx_valid <= 1'b1;
                    st_q       <= IPM_SDO_WAIT;
                end
                IPM_SDO_WAIT: begin
                    // one write at a time: the next waits for the drive's answer
                    if (!o_tx_valid && i_sdo_ack) begin
                        if (step_q == ipm_pkg::IPM_INIT_STEPS - 5'h01) begin
                            o_init_done <= 1'b1;
                            en_q        <= '0;
                            st_q        <= IPM_RUN_WAIT;
                        end else begin
                            step_q <= step_q + 5'h01;
                            st_q   <= IPM_SDO_SEND;
                        end
                    end
                end
                IPM_RUN_WAIT: begin
                    if (cyc_end) begin
                        st_q <= IPM_RUN_PDO;
                    end
                end
                IPM_RUN_PDO: begin
                    if (!o_tx_valid) begin
                        o_tx       <= '{ipm_pkg::IPM_FR_PDO2, 16'h0000, 8'h00, 3'h6, ref_now, cmd_word};
                        o_tx_valid <= 1'b1;
                        last_ref_q <= ref_now;
                        if (en_q != 2'h3) begin
                            en_q <= en_q + 2'h1;
                        end
                        st_q       <= IPM_RUN_SYNC;
                    end
                end
                IPM_RUN_SYNC: begin
                    // sync only after the reference frame left, so the drive moves on fresh data
                    if (tx_done) begin
                        o_tx       <= '{ipm_pkg::IPM_FR_SYNC, 16'h0000, 8'h00, 3'h0, 32'h0, 16'h0000};
                        o_tx_valid <= 1'b1;
                        st_q       <= IPM_RUN_WAIT;
                    end
                end
                default: begin
                    st_q <= IPM_IDLE;
                end
            endcase
        end
    end

    // cycle timer: millisecond prescaler and count of ms within the cycle
    always_ff @(posedge i_mclk) begin
        if (i_rst || st_q != IPM_RUN_WAIT) begin
            pre_q <= '0;
            ms_q  <= '0;
        end else if (ms_tick) begin
            pre_q <= '0;
            ms_q  <= cyc_end ? 5'h00 : ms_q + 5'h01;
        end else begin
            pre_q <= pre_q + 32'h1;
        end
    end

    // link watch: heartbeat is unavailable here, so missing tpdo2 frames count per cycle
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            miss_q        <= '0;
            rx_seen_q     <= 1'b0;
            o_link_lost   <= 1'b0;
            o_mode_active <= 1'b0;
            o_pos_reached <= 1'b0;
            o_act_pos     <= '0;
        end else begin
            if (i_rx_valid) begin
                o_mode_active <= i_rx.state[ipm_pkg::IPM_SW_MODE_BIT];
                o_pos_reached <= i_rx.state[ipm_pkg::IPM_SW_REACH_BIT];
                o_act_pos     <= i_rx.pos;
            end
            if (cyc_end) begin
                rx_seen_q <= i_rx_valid;
                if (rx_seen_q || i_rx_valid) begin
                    miss_q <= '0;
                end else if (miss_q != ipm_pkg::IPM_LOST_CYCLES) begin
                    miss_q <= miss_q + 3'h1;
                end
            end else if (i_rx_valid) begin
                // a tpdo2 ends the loss at once instead of waiting for the cycle end
                rx_seen_q <= 1'b1;
                miss_q    <= '0;
            end
            o_link_lost <= o_init_done && (miss_q == ipm_pkg::IPM_LOST_CYCLES);
        end
    end
endmodule

// file: tb/ipm_master_monitor.sv
// Purpose: port-level checker for the interpolated-position master
// Assumes: node id held constant by the bench
// Notes:   bound onto every ipm_master instance
`timescale 1ns/1ns
module ipm_master_monitor (
    input wire logic                i_mclk,
    input wire logic                i_rst,
    input wire logic [6:0]          i_node_id,
    input wire logic                i_tx_ready,
    input wire logic                i_rx_valid,
    input wire ipm_pkg::ipm_tpdo_t  i_rx,
    input wire ipm_pkg::ipm_frame_t o_tx,
    input wire logic                o_tx_valid,
    input wire logic                o_init_done,
    input wire logic                o_mode_active,
    input wire logic                o_link_lost,
    input wire logic [31:0]         o_act_pos
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    ipm_pkg::ipm_tpdo_t rx_q;
    wire                sdo_f = o_tx.kind == ipm_pkg::IPM_FR_SDO;
    wire                pdo_f = o_tx.kind == ipm_pkg::IPM_FR_PDO2;
    always_ff @(posedge i_mclk) rx_q <= i_rx;

    a_tx_hold_stable: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx))
        else $error("frame changed before accept");
    a_cyclic_after_init: assert property (o_tx_valid && !sdo_f |-> o_init_done)
        else $error("cyclic frame before init done");
    a_sync_follows_pdo: assert property (o_tx_valid && i_tx_ready && pdo_f |=>
        o_tx_valid && o_tx.kind == ipm_pkg::IPM_FR_SYNC) else $error("no sync after pdo2");
    a_resv_bits_zero: assert property (o_tx_valid && pdo_f |-> (o_tx.cmd & ipm_pkg::IPM_CW_RESV_MASK) == 16'h0000)
        else $error("reserved command bits set");
    a_start_needs_power: assert property (o_tx_valid && pdo_f && o_tx.cmd[4] |-> o_tx.cmd[3:0] == 4'hF)
        else $error("start without power stage enabled");
    a_cob_node_add: assert property (o_tx_valid && sdo_f && o_tx.index == 16'h1400 && o_tx.sub == 8'h01
        |-> o_tx.data == 32'h80000200 + i_node_id) else $error("cob-id without node id");
    a_mode_from_rx: assert property (i_rx_valid |=> o_mode_active == rx_q.state[12] && o_act_pos == rx_q.pos)
        else $error("state not taken from tpdo2");
    a_link_clear_rx: assert property (i_rx_valid |-> ##[1:2] !o_link_lost)
        else $error("link lost stays after tpdo2");
    a_init_done_holds: assert property (o_init_done |=> o_init_done)
        else $error("init done dropped");

    c_init_done: cover property ($rose(o_init_done));
    c_mode_start: cover property (o_tx_valid && pdo_f && o_tx.cmd[4]);
    c_link_lost: cover property ($rose(o_link_lost));
endmodule

bind ipm_master ipm_master_monitor u_mon (.i_mclk(i_mclk), .i_rst(i_rst), .i_node_id(i_node_id),
    .i_tx_ready(i_tx_ready), .i_rx_valid(i_rx_valid), .i_rx(i_rx), .o_tx(o_tx), .o_tx_valid(o_tx_valid),
    .o_init_done(o_init_done), .o_mode_active(o_mode_active), .o_link_lost(o_link_lost), .o_act_pos(o_act_pos));

// file: tb/ipm_drive_model.sv
// Purpose: behavioural servo drive at the far side of the master
// Assumes: one frame accepted per ready pulse
// Notes:   position jumps at sync; the fine raster is not modelled
`timescale 1ns/1ns
module ipm_drive_model (
    input  wire logic                i_mclk,
    input  wire logic                i_rst,
    input  wire ipm_pkg::ipm_frame_t i_frame,
    input  wire logic                i_valid,
    input  wire logic                i_slow,
    input  wire logic                i_mute,
    output logic                     o_ready,
    output logic                     o_sdo_ack,
    output logic                     o_rx_valid,
    output ipm_pkg::ipm_tpdo_t       o_rx
);
    ipm_pkg::ipm_frame_t sdo_log [0:31];
    ipm_pkg::ipm_frame_t pdo_log [0:63];
    int                  pdo_t [0:63];
    int                  sdo_n, pdo_n, cyc;
    logic [15:0]         drive_command_word_q, sync_state_q;
    logic [31:0]         ref_q, pos_q;
    logic [1:0]          ack_q, ph_q;
    logic                mode_q, rep_q;
    wire                 acc = i_valid && o_ready;
    wire                 is_sdo = i_frame.kind == ipm_pkg::IPM_FR_SDO;
    wire                 is_pdo = i_frame.kind == ipm_pkg::IPM_FR_PDO2;
    wire                 is_syn = i_frame.kind == ipm_pkg::IPM_FR_SYNC;
    assign o_sdo_ack = ack_q[1];

    always_ff @(posedge i_mclk) begin
        cyc <= cyc + 1;
        ph_q <= ph_q + 2'h1;
        // slow mode stretches the accept so the master must hold its frame
        o_ready <= i_valid && !o_ready && (!i_slow || ph_q[1]);
        ack_q <= {ack_q[0], acc && is_sdo};
        rep_q <= acc && is_syn;
        o_rx_valid <= rep_q && !i_mute;
        // idle bus inverts the word each cycle, so the last word shows every other cycle
        o_rx <= rep_q ? {3'h0, mode_q, 1'b0, pos_q == ref_q, 10'h000, pos_q} : ~o_rx;
        if (acc && is_sdo) begin
            sdo_log[sdo_n] <= i_frame;
            sdo_n <= sdo_n + 1;
            if (i_frame.index == 16'h6040)
                drive_command_word_q <= i_frame.data[15:0];
            if (i_frame.index == 16'h3022 && i_frame.sub == 8'h05)
                sync_state_q <= (i_frame.data == 32'h00000002) ? 16'h0040 : 16'h0001;
        end
        if (acc && is_pdo) begin
            pdo_log[pdo_n] <= i_frame;
            pdo_t[pdo_n] <= cyc;
            pdo_n <= pdo_n + 1;
            drive_command_word_q <= i_frame.cmd;
            ref_q <= i_frame.data;
        end
        if (acc && is_syn) begin
            pos_q <= ref_q;
            mode_q <= drive_command_word_q[4] && drive_command_word_q[3:0] == 4'hF
                && !drive_command_word_q[8];
        end
        if (i_rst) begin
            {sdo_n, pdo_n, ack_q, ph_q, rep_q, mode_q, o_ready, o_rx_valid} <= '0;
            {drive_command_word_q, ref_q, pos_q, o_rx} <= '0;
            sync_state_q <= 16'h0001;
        end
    end
endmodule

// file: tb/ipm_master_tb.sv
// Purpose: self-checking bench for the interpolated-position master
// Assumes: ms shortened to 20 clocks, cycle 2 ms, node id 5
// Notes:   frames are judged from the drive model's logs
`timescale 1ns/1ns
module ipm_master_tb;
    logic                i_mclk, i_rst, i_init, i_run, i_halt, i_ref_valid, slow, mute;
    logic [31:0]         i_ref_pos, o_act_pos;
    ipm_pkg::ipm_frame_t o_tx, f;
    ipm_pkg::ipm_tpdo_t  i_rx;
    logic                o_ref_ready, o_tx_valid, i_tx_ready, i_sdo_ack, i_rx_valid;
    logic                o_init_done, o_mode_active, o_pos_reached, o_link_lost;
    int                  errors, n_compared, k, s;
    int                  cycles = 0;
    logic [60:0]         exp_sdo [0:11];

    ipm_master #(.MS_CYCLES(20)) dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_init(i_init), .i_node_id(7'h05),
        .i_cycle_ms(5'h02), .i_sync_tol(5'h04), .i_run(i_run), .i_halt(i_halt), .i_ref_valid(i_ref_valid),
        .i_ref_pos(i_ref_pos), .o_ref_ready(o_ref_ready), .o_tx(o_tx), .o_tx_valid(o_tx_valid),
        .i_tx_ready(i_tx_ready), .i_sdo_ack(i_sdo_ack), .i_rx_valid(i_rx_valid), .i_rx(i_rx),
        .o_init_done(o_init_done), .o_mode_active(o_mode_active), .o_pos_reached(o_pos_reached),
        .o_link_lost(o_link_lost), .o_act_pos(o_act_pos));
    ipm_drive_model u_drv (.i_mclk(i_mclk), .i_rst(i_rst), .i_frame(o_tx), .i_valid(o_tx_valid),
        .i_slow(slow), .i_mute(mute), .o_ready(i_tx_ready), .o_sdo_ack(i_sdo_ack), .o_rx_valid(i_rx_valid),
        .o_rx(i_rx));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            close_out();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input string name, input logic [63:0] expv, input logic [63:0] got);
        n_compared++;
        if (got !== expv) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, expv, got);
        end
    endtask
    task automatic wait_pdo(input int n);
        int t;
        t = u_drv.pdo_n + n;
        while (u_drv.pdo_n < t) tick(1);
    endtask
    task automatic step(input logic run, input logic halt, input logic expm);
        i_run = run;
        i_halt = halt;
        wait_pdo(3);
        tick(8);
        chk("mode_active", expm, o_mode_active);
    endtask
    task automatic close_out();
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        exp_sdo = '{{5'h00, 16'h1400, 8'h01, 32'h80000205},
                    {5'h03, 16'h1801, 8'h01, 32'h00000285},
                    {5'h0E, 16'h1601, 8'h02, 32'h60C10120},
                    {5'h0F, 16'h1601, 8'h00, 32'h00000002},
                    {5'h12, 16'h1A01, 8'h02, 32'h60640020},
                    {5'h14, 16'h3006, 8'h07, 32'h00020000},
                    {5'h16, 16'h6060, 8'h00, 32'h00000007},
                    {5'h17, 16'h3006, 8'h3D, 32'h00000001},
                    {5'h18, 16'h60C2, 8'h01, 32'h00000002},
                    {5'h1A, 16'h3013, 8'h06, 32'h000003E8},
                    {5'h1B, 16'h3006, 8'h06, 32'h00000001},
                    {5'h1C, 16'h3022, 8'h04, 32'h00000004}};
        {i_rst, slow} = 2'h3;
        {i_init, i_run, i_halt, i_ref_valid, mute, i_ref_pos} = '0;
        tick(4);
        i_rst = 1'b0;
        // fill the buffer before any cyclic drain exists
        i_ref_valid = 1'b1;
        for (k = 0; k < 4; k++) begin
            i_ref_pos = 32'h00000100 * (k + 1);
            while (o_ref_ready !== 1'b1) tick(1);
            tick(1);
        end
        i_ref_valid = 1'b0;
        tick(1);
        chk("ref_ready_full", 0, o_ref_ready);
        i_init = 1'b1;
        tick(1);
        i_init = 1'b0;
        while (o_init_done !== 1'b1) tick(1);
        chk("sdo_count", 30, u_drv.sdo_n);
        chk("sync_activate", {16'h3022, 8'h05, 32'h2}, {u_drv.sdo_log[29].index, u_drv.sdo_log[29].sub, u_drv.sdo_log[29].data});
        for (k = 0; k < 12; k++) begin
            s = exp_sdo[k][60:56];
            f = u_drv.sdo_log[s];
            chk("sdo_write", exp_sdo[k][55:0], {f.index, f.sub, f.data});
        end
        i_run = 1'b1;
        slow = 1'b0;
        wait_pdo(6);
        tick(8);
        for (k = 0; k < 6; k++) chk("pdo_ref", 32'h100 * (k < 4 ? k + 1 : 4), u_drv.pdo_log[k].data);
        chk("cmd_1", 16'h0006, u_drv.pdo_log[0].cmd);
        chk("cmd_2", 16'h0007, u_drv.pdo_log[1].cmd);
        chk("cmd_3", 16'h000F, u_drv.pdo_log[2].cmd);
        chk("cmd_4", 16'h001F, u_drv.pdo_log[3].cmd);
        chk("mode_active", 1, o_mode_active);
        chk("pos_reached", 1, o_pos_reached);
        chk("act_pos", 32'h00000400, o_act_pos);
        k = u_drv.pdo_t[5] - u_drv.pdo_t[4];
        chk("cycle_len", 1, k >= 40 && k <= 50);
        step(1'b1, 1'b1, 1'b0);
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b0);
        mute = 1'b1;
        wait_pdo(5);
        tick(2);
        chk("link_lost", 1, o_link_lost);
        mute = 1'b0;
        wait_pdo(2);
        tick(8);
        chk("link_lost", 0, o_link_lost);
        close_out();
    end
endmodule
